// ===== ppcs_top.sv
// Chip-select configuration registers, strobe polarity and window decode for the parallel port.
`timescale 1ns/1ns
// Summary of operation
// RQ1: Master mode with style bit set uses combined read/write plus enable strobe.
// RQ2: Separate-strobe or slave mode: write polarity bit sets write strobe level.
// RQ3: Combined-strobe master mode: write polarity bit sets enable strobe level.
// RQ4: Read polarity bit sets read strobe, or combined strobe, active level.
// RQ5: Port width field: 00 eight lanes, 01 four, 10 sixteen, 11 reserved.
// RQ6: Base register holds address bits 23..15 in register bits 15..7.
// RQ7: Reset loads base one with 0080h and base two with 0880h.
// RQ8: Whole-word zero write to base two extends window one to FFFFFFh.
// RQ9: Zero write to base one causes no extension.
// RQ10: Unimplemented base and configuration bits read zero, ignore writes.
// RQ11: Lane enable polarity bit chooses active-high or active-low lane enables.
// RQ12: Acknowledge polarity bit chooses active level of acknowledge input.
module ppcs_top
  import ppcs_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              master_mode_i,
  input  wire logic [23:0]       xfer_addr_i,
  input  wire logic              xfer_rd_i,
  input  wire logic              xfer_wr_i,
  input  wire logic              xfer_en_i,
  input  wire logic [1:0]        xfer_lane_i,
  input  wire logic              acknowledge_in_one_i,
  output logic                   read_strobe_out_o,
  output logic                   write_strobe_out_o,
  output logic                   enable_strobe_out_o,
  output logic                   lane_enable_low_o,
  output logic                   lane_enable_high_o,
  output logic                   ack_active_o,
  output logic [15:0]            lane_mask_o,
  output logic                   cs1_hit_o,
  output logic                   cs2_hit_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [15:0] cs1_cfg_reg;
  logic [15:0] cs2_cfg_reg;
  logic [15:0] cs1_base_reg;
  logic [15:0] cs2_base_reg;
  logic        extend_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cs1_cfg_reg <= CFG_RST;
      cs2_cfg_reg <= CFG_RST;
    end else if (reg_wr_i) begin
      // RQ10: masked configuration writes
      if (reg_addr_i == OFF_CS1_CFG) begin
        cs1_cfg_reg <= reg_wdata_i & CFG_MASK;
      end else if (reg_addr_i == OFF_CS2_CFG) begin
        cs2_cfg_reg <= reg_wdata_i & CFG_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      // RQ7: base reset values
      cs1_base_reg <= CS1_BASE_RST;
      cs2_base_reg <= CS2_BASE_RST;
    end else if (reg_wr_i) begin
      // RQ10: masked base writes
      if (reg_addr_i == OFF_CS1_BASE) begin
        cs1_base_reg <= reg_wdata_i & BASE_MASK;
      end else if (reg_addr_i == OFF_CS2_BASE) begin
        cs2_base_reg <= reg_wdata_i & BASE_MASK;
      end
    end
  end

  // Extension flag follows the most recent write of base two only.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      extend_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == OFF_CS2_BASE) begin
      // RQ8: whole-word zero write
      extend_reg <= (reg_wdata_i == ZERO16);
    end
    // RQ9: base one writes never touch the extension flag.
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.

  logic [15:0] rdata_next;

  always_comb begin
    if (reg_addr_i == OFF_CS1_CFG) begin
      rdata_next = cs1_cfg_reg;
    end else if (reg_addr_i == OFF_CS2_CFG) begin
      rdata_next = cs2_cfg_reg;
    end else if (reg_addr_i == OFF_CS1_BASE) begin
      rdata_next = cs1_base_reg;
    end else if (reg_addr_i == OFF_CS2_BASE) begin
      rdata_next = cs2_base_reg;
    end else if (reg_addr_i == OFF_STATUS) begin
      rdata_next = {13'h0000, extend_reg, cs2_hit_o, cs1_hit_o};
    end else begin
      rdata_next = ZERO16;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= ZERO16;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end else begin
      reg_rdata_o <= ZERO16;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window decode and chip-select choice.

  logic hit1;
  logic hit2;

  ppcs_window u_win1 (
    .base_i      (cs1_base_reg),
    .next_base_i (cs2_base_reg),
    .extend_i    (extend_reg),
    .last_i      (1'b0),
    .addr_i      (xfer_addr_i),
    .hit_o       (hit1)
  );

  ppcs_window u_win2 (
    .base_i      (cs2_base_reg),
    .next_base_i (cs2_base_reg),
    .extend_i    (1'b0),
    .last_i      (1'b1),
    .addr_i      (xfer_addr_i),
    .hit_o       (hit2)
  );

  // Chip select two is unusable while the window of one is extended.
  logic sel2;
  assign sel2 = hit2 & ~extend_reg;

  logic [15:0] cfg_sel;
  assign cfg_sel = sel2 ? cs2_cfg_reg : cs1_cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin polarity mapping.

  logic       rd_pin;
  logic       wr_pin;
  logic       en_pin;
  logic [1:0] lane_pin;
  logic       ack_act;
  logic [15:0] mask;

  ppcs_strobe u_strobe (
    .master_i    (master_mode_i),
    .cfg_i       (cfg_sel),
    .rd_act_i    (xfer_rd_i),
    .wr_act_i    (xfer_wr_i),
    .en_act_i    (xfer_en_i),
    .lane_act_i  (xfer_lane_i),
    .ack_pin_i   (acknowledge_in_one_i),
    .rd_pin_o    (rd_pin),
    .wr_pin_o    (wr_pin),
    .en_pin_o    (en_pin),
    .lane_pin_o  (lane_pin),
    .ack_act_o   (ack_act),
    .data_mask_o (mask)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      read_strobe_out_o   <= 1'b1;
      write_strobe_out_o  <= 1'b1;
      enable_strobe_out_o <= 1'b1;
      lane_enable_low_o   <= 1'b1;
      lane_enable_high_o  <= 1'b1;
      ack_active_o        <= 1'b0;
      lane_mask_o         <= 16'h00ff;
      cs1_hit_o           <= 1'b0;
      cs2_hit_o           <= 1'b0;
    end else begin
      read_strobe_out_o   <= rd_pin;
      write_strobe_out_o  <= wr_pin;
      enable_strobe_out_o <= en_pin;
      lane_enable_low_o   <= lane_pin[0];
      lane_enable_high_o  <= lane_pin[1];
      ack_active_o        <= ack_act;
      lane_mask_o         <= mask;
      cs1_hit_o           <= hit1 & ~sel2;
      cs2_hit_o           <= sel2;
    end
  end

endmodule

// ===== ppcs_pkg.sv
// Package with register map, field positions and reset values for the chip-select configuration block.
package ppcs_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // Register offsets (word addresses on the register port).
  localparam logic [3:0] OFF_CS1_CFG  = 4'h0;
  localparam logic [3:0] OFF_CS2_CFG  = 4'h1;
  localparam logic [3:0] OFF_CS1_BASE = 4'h2;
  localparam logic [3:0] OFF_CS2_BASE = 4'h3;
  localparam logic [3:0] OFF_STATUS   = 4'h4;

  // Configuration register field positions.
  localparam int unsigned CFG_BYTE_ENABLE_POLARITY_BIT  = 12;
  localparam int unsigned CFG_WRITE_STROBE_POLARITY_BIT = 10;
  localparam int unsigned CFG_READ_STROBE_POLARITY_BIT  = 9;
  localparam int unsigned CFG_STROBE_STYLE_SELECT_BIT   = 8;
  localparam int unsigned CFG_ACKNOWLEDGE_POLARITY_BIT  = 7;
  localparam int unsigned CFG_PW_HI                     = 6;
  localparam int unsigned CFG_PW_LO                     = 5;

  // Writable bit masks; all other bits are unimplemented and read zero.
  localparam logic [15:0] CFG_MASK  = 16'h17e0;
  localparam logic [15:0] BASE_MASK = 16'hff80;

  // Reset values.
  localparam logic [15:0] CFG_RST      = 16'h0000;
  localparam logic [15:0] CS1_BASE_RST = 16'h0080;
  localparam logic [15:0] CS2_BASE_RST = 16'h0880;
  localparam logic [15:0] ZERO16       = 16'h0000;

  // Port width field encodings.
  localparam logic [1:0] PW_8BIT  = 2'b00;
  localparam logic [1:0] PW_4BIT  = 2'b01;
  localparam logic [1:0] PW_16BIT = 2'b10;

  // Last address of chip select 1 when its window is extended.
  localparam logic [23:0] ADDR_TOP = 24'hffffff;

endpackage

// ===== ppcs_strobe.sv
// Per-chip-select strobe, lane-enable and acknowledge polarity mapping.
`timescale 1ns/1ns
module ppcs_strobe
  import ppcs_pkg::*;
(
  input  wire logic        master_i,
  input  wire logic [15:0] cfg_i,
  input  wire logic        rd_act_i,
  input  wire logic        wr_act_i,
  input  wire logic        en_act_i,
  input  wire logic [1:0]  lane_act_i,
  input  wire logic        ack_pin_i,
  output logic             rd_pin_o,
  output logic             wr_pin_o,
  output logic             en_pin_o,
  output logic [1:0]       lane_pin_o,
  output logic             ack_act_o,
  output logic [15:0]      data_mask_o
);

  logic combined;
  logic wr_pol;
  logic rd_pol;
  logic lane_pol;

  assign combined = master_i & cfg_i[CFG_STROBE_STYLE_SELECT_BIT];
  assign wr_pol   = cfg_i[CFG_WRITE_STROBE_POLARITY_BIT];
  assign rd_pol   = cfg_i[CFG_READ_STROBE_POLARITY_BIT];
  assign lane_pol = cfg_i[CFG_BYTE_ENABLE_POLARITY_BIT];

  always_comb begin
    // RQ1: strobe style select
    if (combined) begin
      // RQ4: combined strobe polarity
      rd_pin_o = (rd_act_i ? 1'b0 : 1'b1) ~^ rd_pol;
      // RQ3: enable strobe polarity
      en_pin_o = en_act_i ~^ wr_pol;
      wr_pin_o = ~wr_pol;
    end else begin
      // RQ4: read strobe polarity
      rd_pin_o = rd_act_i ~^ rd_pol;
      // RQ2: write strobe polarity
      wr_pin_o = wr_act_i ~^ wr_pol;
      en_pin_o = ~wr_pol;
    end
  end

  // RQ11: lane enable polarity
  assign lane_pin_o = lane_pol ? lane_act_i : ~lane_act_i;

  // RQ12: acknowledge polarity
  assign ack_act_o = ack_pin_i ~^ cfg_i[CFG_ACKNOWLEDGE_POLARITY_BIT];

  always_comb begin
    // RQ5: port width lanes
    case (cfg_i[CFG_PW_HI:CFG_PW_LO])
      PW_8BIT:  data_mask_o = 16'h00ff;
      PW_4BIT:  data_mask_o = 16'h000f;
      PW_16BIT: data_mask_o = 16'hffff;
      default:  data_mask_o = 16'h0000;
    endcase
  end

endmodule

// ===== ppcs_window.sv
// Address window decode for one chip select against its base and the next base.
`timescale 1ns/1ns
module ppcs_window
  import ppcs_pkg::*;
(
  input  wire logic [15:0] base_i,
  input  wire logic [15:0] next_base_i,
  input  wire logic        extend_i,
  input  wire logic        last_i,
  input  wire logic [23:0] addr_i,
  output logic             hit_o
);

  logic [23:0] lo;
  logic [23:0] hi;

  // RQ6: base address bits 23..15
  assign lo = {base_i[15:7], 15'h0000};
  assign hi = {next_base_i[15:7], 15'h0000};

  always_comb begin
    // RQ8: extended window to top
    if (extend_i || last_i) begin
      hit_o = (addr_i >= lo) && (addr_i <= ADDR_TOP);
    end else begin
      hit_o = (addr_i >= lo) && (addr_i < hi);
    end
  end

endmodule

// ===== ppcs_top_monitor.sv
// Concurrent checks on the ports of the chip-select configuration block.
`timescale 1ns/1ns
module ppcs_top_monitor
  import ppcs_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic              master_mode_i,
  input wire logic              xfer_rd_i,
  input wire logic              xfer_wr_i,
  input wire logic              xfer_en_i,
  input wire logic [1:0]        xfer_lane_i,
  input wire logic              acknowledge_in_one_i,
  input wire logic              read_strobe_out_o,
  input wire logic              write_strobe_out_o,
  input wire logic              enable_strobe_out_o,
  input wire logic              lane_enable_low_o,
  input wire logic              lane_enable_high_o,
  input wire logic              ack_active_o,
  input wire logic [15:0]       lane_mask_o
);
  // Pin checks run only while both configurations agree, so selection does not matter.
  logic [15:0] c1_reg;
  logic [15:0] c2_reg;
  wire         w1   = reg_wr_i && reg_addr_i == OFF_CS1_CFG;
  wire         w2   = reg_wr_i && reg_addr_i == OFF_CS2_CFG;
  always_ff @(posedge clk_sys_i) c1_reg <= !rst_n_i ? CFG_RST : w1 ? reg_wdata_i & CFG_MASK : c1_reg;
  always_ff @(posedge clk_sys_i) c2_reg <= !rst_n_i ? CFG_RST : w2 ? reg_wdata_i & CFG_MASK : c2_reg;
  wire         same = c1_reg == c2_reg;
  wire         cmb  = master_mode_i & c1_reg[8];
  wire         wp   = c1_reg[10];
  wire         rp   = c1_reg[9];
  wire         bp   = c1_reg[12];
  wire         ap   = c1_reg[7];
  wire  [1:0]  pw   = c1_reg[6:5];
  wire  [15:0] wm   = pw == PW_8BIT ? 16'h00ff : pw == PW_4BIT ? 16'h000f : pw == PW_16BIT ? 16'hffff : 16'h0000;
  wire  [1:0]  lp   = {lane_enable_high_o, lane_enable_low_o};
  wire         rd_c = reg_rd_i && (reg_addr_i == OFF_CS1_CFG || reg_addr_i == OFF_CS2_CFG);
  wire         rd_b = reg_rd_i && (reg_addr_i == OFF_CS1_BASE || reg_addr_i == OFF_CS2_BASE);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////
  a_sep_wr_level: assert property (same && !cmb |=> write_strobe_out_o == ($past(xfer_wr_i) ~^ $past(wp)))
    else $error("write strobe level wrong");
  a_sep_rd_level: assert property (same && !cmb |=> read_strobe_out_o == ($past(xfer_rd_i) ~^ $past(rp)))
    else $error("read strobe level wrong");
  a_comb_rw_level: assert property (same && cmb |=> read_strobe_out_o == (!$past(xfer_rd_i) ~^ $past(rp)))
    else $error("combined strobe level wrong");
  a_comb_wr_idle: assert property (same && cmb |=> write_strobe_out_o == !$past(wp))
    else $error("write strobe not idle");
  a_comb_en_level: assert property (same && cmb |=> enable_strobe_out_o == ($past(xfer_en_i) ~^ $past(wp)))
    else $error("enable strobe level wrong");
  a_lane_level: assert property (same |=> lp == ($past(xfer_lane_i) ~^ {2{$past(bp)}}))
    else $error("lane enable level wrong");
  a_ack_sense: assert property (same |=> ack_active_o == ($past(acknowledge_in_one_i) ~^ $past(ap)))
    else $error("acknowledge sense wrong");
  a_lane_width: assert property (same |=> lane_mask_o == $past(wm))
    else $error("lane mask wrong");
  a_sep_en_idle: assert property (same && !cmb |=> enable_strobe_out_o == !$past(wp))
    else $error("enable strobe not idle");
  a_cfg_rd_zero: assert property (rd_c |=> reg_rdata_o[4:0] == 5'h00)
    else $error("config unimplemented bits not zero");
  a_base_rd_zero: assert property (rd_b |=> reg_rdata_o[6:0] == 7'h00)
    else $error("base unimplemented bits not zero");
endmodule

// ===== ppcs_periph.sv
// Model of an external part that answers on the acknowledge pin.
`timescale 1ns/1ns
module ppcs_periph (
  input  wire logic clk_i,
  input  wire logic req_i,
  input  wire logic slow_i,
  input  wire logic ack_pol_i,
  output logic      ack_o
);
  logic [1:0] dly_reg;
  always_ff @(posedge clk_i) dly_reg <= {dly_reg[0], req_i};
  assign ack_o = (slow_i ? dly_reg[1] : dly_reg[0]) ~^ ack_pol_i;
endmodule

// ===== ppcs_top_test.sv
// Self-checking bench for the chip-select configuration block.
`timescale 1ns/1ns
module ppcs_top_test
  import ppcs_pkg::*;
;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, master_mode_i = 1'b0;
  logic        xfer_rd_i = 1'b0, xfer_wr_i = 1'b0, xfer_en_i = 1'b0, req = 1'b0, slow = 1'b0, apol = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [23:0] xfer_addr_i = 24'h000000;
  logic [1:0]  xfer_lane_i = 2'h0;
  logic        acknowledge_in_one_i, read_strobe_out_o, write_strobe_out_o, enable_strobe_out_o, cs1_hit_o;
  logic        lane_enable_low_o, lane_enable_high_o, ack_active_o, cs2_hit_o;
  logic [15:0] reg_rdata_o, lane_mask_o;
  int          error_cnt = 0;
  int          total_checks = 0;
  ppcs_top i_dut (.*);
  ppcs_periph i_peer (.clk_i(clk_sys_i), .req_i(req), .slow_i(slow), .ack_pol_i(apol), .ack_o(acknowledge_in_one_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // A read passes the expected word in d and compares it in the answer cycle.
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    if (!w) chk(reg_rdata_o, d);
  endtask
  task automatic cfg(input logic [15:0] d);
    bus(1'b1, OFF_CS1_CFG, d);
    bus(1'b1, OFF_CS2_CFG, d);
  endtask
  task automatic hit(input logic [23:0] a, input logic [1:0] e);
    @(posedge clk_sys_i);
    xfer_addr_i <= a;
    wt(1);
    chk({cs1_hit_o, cs2_hit_o}, e);
  endtask
  task automatic t_regs;
    bus(1'b0, OFF_CS1_BASE, 16'h0080);
    bus(1'b0, OFF_CS2_BASE, 16'h0880);
    bus(1'b0, 4'hf, 16'h0000);
    bus(1'b1, OFF_CS1_CFG, 16'hffff);
    bus(1'b0, OFF_CS1_CFG, 16'h17e0);
    bus(1'b1, OFF_CS2_BASE, 16'hffff);
    bus(1'b0, OFF_CS2_BASE, 16'hff80);
    bus(1'b1, OFF_CS2_BASE, 16'h0880);
  endtask
  task automatic t_strobes;
    logic m, s, w, r;
    for (int i = 0; i < 16; i++) begin
      {m, s, w, r} = 4'(i);
      cfg({5'h00, w, r, s, 8'h00});
      for (int ph = 0; ph < 2; ph++) begin
        @(posedge clk_sys_i);
        master_mode_i <= m;
        xfer_wr_i <= ph[0];
        xfer_rd_i <= !ph[0];
        xfer_en_i <= ph[0];
        wt(1);
        if (m && s) begin
          chk(read_strobe_out_o, {!xfer_rd_i ~^ r});
          chk(enable_strobe_out_o, {xfer_en_i ~^ w});
          chk(write_strobe_out_o, {!w});
        end else begin
          chk(write_strobe_out_o, {xfer_wr_i ~^ w});
          chk(read_strobe_out_o, {xfer_rd_i ~^ r});
          chk(enable_strobe_out_o, {!w});
        end
      end
    end
  endtask
  task automatic t_lanes;
    logic [15:0] wm [4] = '{16'h00ff, 16'h000f, 16'hffff, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      cfg({3'h0, i[2], 4'h0, !i[2], i[1:0], 5'h00});
      @(posedge clk_sys_i);
      apol <= !i[2];
      req <= i[0];
      slow <= i[1];
      xfer_lane_i <= i[1:0];
      wt(4);
      chk({lane_enable_high_o, lane_enable_low_o}, {xfer_lane_i ~^ {2{i[2]}}});
      chk(lane_mask_o, wm[i[1:0]]);
      chk(ack_active_o, req);
    end
  endtask
  task automatic t_window;
    hit(24'h007fff, 2'b00);
    hit(24'h008000, 2'b10);
    hit(24'h087fff, 2'b10);
    hit(24'hffffff, 2'b01);
    bus(1'b1, OFF_CS2_BASE, 16'h0000);
    hit(24'hffffff, 2'b10);
    hit(24'h088000, 2'b10);
    bus(1'b0, OFF_STATUS, 16'h0005);
    bus(1'b1, OFF_CS2_BASE, 16'h007f);
    hit(24'h088000, 2'b01);
    bus(1'b1, OFF_CS2_BASE, 16'h0880);
    bus(1'b1, OFF_CS1_BASE, 16'h0000);
    hit(24'h088000, 2'b01);
    hit(24'h000000, 2'b10);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_strobes;
    t_lanes;
    t_window;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    error_cnt++;
    stop_test;
  end
endmodule
bind ppcs_top ppcs_top_monitor i_mon (.*);
